/* rtl/adc_control_status_result.sv */
// The AXI4-Lite slave port was left to the implementer.
`include "adc_ctrl_defs.svh"

module adc_control_status_result (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic standby,
  input wire logic dma_access,
  input wire logic [9:0] sample_data,
  output logic sample_start,
  output logic [2:0] sample_channel,
  output logic conv_done_interrupt
);
  // write channel state
  logic aw_got;
  logic w_got;
  logic [29:0] wr_index;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic next_awready;
  logic next_wready;
  logic next_aw_got;
  logic next_w_got;
  logic [29:0] next_wr_index;
  logic [31:0] next_wr_data;
  logic [3:0] next_wr_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic write_fire;
  logic write_mapped;

  // read channel state
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic read_fire;
  logic [29:0] rd_index;

  // control/status and sequencer state
  logic conv_done_flag;
  logic done_irq_enable;
  logic conv_start_bit;
  logic scan_mode;
  logic conv_time_select;
  adc_types_pkg::channel_t channel_select_field;
  logic flag_read_armed;
  adc_types_pkg::seq_state_t state;
  adc_types_pkg::channel_t cur_channel;
  logic next_flag;
  logic next_irq_enable;
  logic next_start;
  logic next_scan;
  logic next_time_sel;
  adc_types_pkg::channel_t next_channel_field;
  logic next_armed;
  adc_types_pkg::seq_state_t next_state;
  adc_types_pkg::channel_t next_cur_channel;
  logic next_sample_start;
  logic next_irq;
  logic timer_begin;
  logic timer_abort;
  logic timer_done;
  logic store_result;
  logic [7:0] control_byte;
  logic [63:0] results;
  logic ctrl_write;

  assign control_byte = {conv_done_flag, done_irq_enable, conv_start_bit, scan_mode,
                         conv_time_select, channel_select_field};

  // ---------------- write channel ----------------
  always_comb begin
    next_awready = 1'b0;
    next_wready = 1'b0;
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_wr_index = wr_index;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    write_fire = aw_got && w_got && !s_axi_bvalid;
    write_mapped = (wr_index == `IDX_CONTROL) || (wr_index == `IDX_RESULT_A) ||
                   (wr_index == `IDX_RESULT_B) || (wr_index == `IDX_RESULT_C) ||
                   (wr_index == `IDX_RESULT_D);
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_wr_index = s_axi_awaddr[31:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_wr_data = s_axi_wdata;
      next_wr_strb = s_axi_wstrb;
    end
    // ready is a single-cycle pulse so a held valid is never taken twice
    if (s_axi_awvalid && !s_axi_awready && !aw_got && !s_axi_bvalid) begin
      next_awready = 1'b1;
    end
    if (s_axi_wvalid && !s_axi_wready && !w_got && !s_axi_bvalid) begin
      next_wready = 1'b1;
    end
    if (write_fire) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      // result registers accept writes silently; only holes answer with an error
      next_bresp = write_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_index <= 30'h0000000;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      wr_index <= next_wr_index;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  // ---------------- read channel ----------------
  always_comb begin
    next_arready = 1'b0;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    read_fire = s_axi_arvalid && s_axi_arready;
    rd_index = s_axi_araddr[31:2];
    if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
      next_arready = 1'b1;
    end
    if (read_fire) begin
      next_rvalid = 1'b1;
      next_rresp = `RESP_OKAY;
      // upper half and unused low bits read zero
      case (rd_index)
        `IDX_CONTROL: next_rdata = {24'h000000, control_byte};
        `IDX_RESULT_A: next_rdata = {16'h0000, results[15:0]};
        `IDX_RESULT_B: next_rdata = {16'h0000, results[31:16]};
        `IDX_RESULT_C: next_rdata = {16'h0000, results[47:32]};
        `IDX_RESULT_D: next_rdata = {16'h0000, results[63:48]};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ---------------- control/status and sequencer ----------------
  always_comb begin
    next_flag = conv_done_flag;
    next_irq_enable = done_irq_enable;
    next_start = conv_start_bit;
    next_scan = scan_mode;
    next_time_sel = conv_time_select;
    next_channel_field = channel_select_field;
    next_armed = flag_read_armed;
    next_state = state;
    next_cur_channel = cur_channel;
    next_sample_start = 1'b0;
    timer_begin = 1'b0;
    timer_abort = 1'b0;
    store_result = 1'b0;
    ctrl_write = write_fire && (wr_index == `IDX_CONTROL) && wr_strb[0];

    // reading the flag as one arms the zero-write clear
    if (read_fire && (rd_index == `IDX_CONTROL) && conv_done_flag) begin
      next_armed = 1'b1;
    end
    if (ctrl_write) begin
      next_irq_enable = wr_data[`BIT_IRQ_ENABLE];
      next_start = wr_data[`BIT_START];
      next_scan = wr_data[`BIT_SCAN];
      next_time_sel = wr_data[`BIT_TIME_SEL];
      next_channel_field = wr_data[`CHAN_MSB:`CHAN_LSB];
      // zero clears only when armed, one is ignored
      if (!wr_data[`BIT_DONE_FLAG] && flag_read_armed) begin
        next_flag = 1'b0;
        next_armed = 1'b0;
      end
    end
    if (dma_access) begin
      next_flag = 1'b0;
      next_armed = 1'b0;
    end

    case (state)
      adc_types_pkg::SEQ_IDLE: begin
        if (conv_start_bit) begin
          timer_begin = 1'b1;
          next_sample_start = 1'b1;
          next_state = adc_types_pkg::SEQ_CONVERT;
          // single input or first input of the group
          if (scan_mode) begin
            next_cur_channel = {channel_select_field[2], 2'b00};
          end else begin
            next_cur_channel = channel_select_field;
          end
        end
      end
      adc_types_pkg::SEQ_CONVERT: begin
        if (!conv_start_bit) begin
          // clearing start stops the scan, even mid-conversion
          timer_abort = 1'b1;
          next_state = adc_types_pkg::SEQ_IDLE;
        end else if (timer_done) begin
          store_result = 1'b1;
          // mode decides start and flag handling
          if (!scan_mode) begin
            next_start = 1'b0;
            next_flag = 1'b1;
            next_state = adc_types_pkg::SEQ_IDLE;
          end else begin
            timer_begin = 1'b1;
            next_sample_start = 1'b1;
            if (cur_channel == channel_select_field) begin
              next_flag = 1'b1;
              next_cur_channel = {channel_select_field[2], 2'b00};
            end else begin
              next_cur_channel = 3'(cur_channel + 3'h1);
            end
          end
        end
      end
      default: begin
        next_state = adc_types_pkg::SEQ_IDLE;
      end
    endcase

    // standby returns the control bits, sequencer and results to reset; cur_channel and the bus channels keep their state
    if (standby) begin
      next_flag = 1'b0;
      next_irq_enable = 1'b0;
      next_start = 1'b0;
      next_scan = 1'b0;
      next_time_sel = 1'b0;
      next_channel_field = 3'h4;
      next_armed = 1'b0;
      next_state = adc_types_pkg::SEQ_IDLE;
      next_sample_start = 1'b0;
      timer_begin = 1'b0;
      timer_abort = 1'b1;
      store_result = 1'b0;
    end
    next_irq = next_flag && next_irq_enable;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_done_flag <= 1'(`CONTROL_RESET >> `BIT_DONE_FLAG);
      done_irq_enable <= 1'b0;
      conv_start_bit <= 1'b0;
      scan_mode <= 1'b0;
      conv_time_select <= 1'b0;
      channel_select_field <= 3'h4;
      flag_read_armed <= 1'b0;
      state <= adc_types_pkg::SEQ_IDLE;
      cur_channel <= 3'h0;
      sample_start <= 1'b0;
      sample_channel <= 3'h0;
      conv_done_interrupt <= 1'b0;
    end else begin
      conv_done_flag <= next_flag;
      done_irq_enable <= next_irq_enable;
      conv_start_bit <= next_start;
      scan_mode <= next_scan;
      conv_time_select <= next_time_sel;
      channel_select_field <= next_channel_field;
      flag_read_armed <= next_armed;
      state <= next_state;
      cur_channel <= next_cur_channel;
      sample_start <= next_sample_start;
      sample_channel <= next_cur_channel;
      conv_done_interrupt <= next_irq;
    end
  end

  conversion_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .begin_conv(timer_begin),
    .abort(timer_abort),
    .fast_sel(conv_time_select),
    .done(timer_done)
  );

  // channel n lands in result register n modulo four
  result_store #(
    .RESULTS(4)
  ) u_results (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(standby),
    .store(store_result),
    .store_index(cur_channel[1:0]),
    .store_value(sample_data),
    .results(results)
  );
endmodule

/* rtl/adc_ctrl_defs.svh */
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// register indices as printed; the byte address is four times the index
`define IDX_RESULT_A 30'h5FFFEE0
`define IDX_RESULT_B 30'h5FFFEE2
`define IDX_RESULT_C 30'h5FFFEE4
`define IDX_RESULT_D 30'h5FFFEE6
`define IDX_CONTROL 30'h5FFFEF8

// control/status bit positions
`define BIT_DONE_FLAG 7
`define BIT_IRQ_ENABLE 6
`define BIT_START 5
`define BIT_SCAN 4
`define BIT_TIME_SEL 3
`define CHAN_MSB 2
`define CHAN_LSB 0

// reset values
`define CONTROL_RESET 8'h04
`define RESULT_RESET 16'h0000

// result layout: 10-bit value left-aligned in a 16-bit word
`define RESULT_SHIFT 6

// conversion lengths in system clock cycles
`define CONV_CYCLES_SLOW 8'hEC
`define CONV_CYCLES_FAST 8'h86

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* rtl/adc_types_pkg.sv */
package adc_types_pkg;
  typedef enum logic [0:0] {SEQ_IDLE, SEQ_CONVERT} seq_state_t;
  typedef logic [2:0] channel_t;
endpackage

/* rtl/conversion_timer.sv */
`include "adc_ctrl_defs.svh"

module conversion_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic begin_conv,
  input wire logic abort,
  input wire logic fast_sel,
  output logic done
);
  logic [7:0] count;
  logic busy;
  logic [7:0] next_count;
  logic next_busy;
  logic next_done;

  always_comb begin
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    if (abort) begin
      next_count = 8'h00;
      next_busy = 1'b0;
    end else if (begin_conv) begin
      next_count = (fast_sel ? `CONV_CYCLES_FAST : `CONV_CYCLES_SLOW) - 8'h01;
      next_busy = 1'b1;
    end else if (busy) begin
      if (count == 8'h00) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end
endmodule

/* rtl/result_store.sv */
`include "adc_ctrl_defs.svh"

module result_store #(
  parameter int RESULTS = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic store,
  input wire logic [1:0] store_index,
  input wire logic [9:0] store_value,
  output logic [RESULTS*16-1:0] results
);
  genvar i;
  generate
    for (i = 0; i < RESULTS; i = i + 1) begin : g_res
      // each word has its own flop; the output vector is only wired from them
      logic [15:0] word;
      logic [15:0] next_word;
      always_comb begin
        next_word = word;
        if (clear) begin
          next_word = `RESULT_RESET;
        end else if (store && (store_index == 2'(i))) begin
          // upper eight bits high; low two at 7,6, rest zero
          next_word = {store_value, 6'h00};
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          word <= `RESULT_RESET;
        end else begin
          word <= next_word;
        end
      end
      assign results[i*16 +: 16] = word;
    end
  endgenerate
endmodule

/* verification/adc_control_status_result_properties.sv */
module adc_csr_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic standby,
  input wire logic dma_access,
  input wire logic sample_start,
  input wire logic [2:0] sample_channel,
  input wire logic conv_done_interrupt
);
  // cycles since the last conversion began, saturating so idle time never wraps
  logic [8:0] age;
  logic [8:0] next_age;
  always_comb begin
    next_age = age;
    if (sample_start) next_age = 9'h001;
    else if (age != 9'h1FF) next_age = age + 9'h001;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) age <= 9'h1FF;
    else age <= next_age;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_reset_quiet;
    @(posedge aclk) disable iff (1'h0)
    !aresetn |=> !conv_done_interrupt && !sample_start && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
  property p_standby;
    standby |=> !conv_done_interrupt && !sample_start;
  endproperty
  a_standby: assert property (p_standby) else $error("standby did not stop");
  property p_dma;
    dma_access && age < 9'h064 |=> !conv_done_interrupt;
  endproperty
  a_dma: assert property (p_dma) else $error("dma left flag set");
  property p_start_gap;
    sample_start |=> !sample_start [*8];
  endproperty
  a_start_gap: assert property (p_start_gap) else $error("starts too close");
  property p_irq_time;
    $rose(conv_done_interrupt) && !$rose(s_axi_bvalid) |-> age > 9'h082 && age < 9'h0F5;
  endproperty
  a_irq_time: assert property (p_irq_time) else $error("done at wrong time");
  property p_chan_hold;
    sample_start |=> standby || $stable(sample_channel);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
  property p_rdata_hi;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
  property p_irq_hold;
    conv_done_interrupt && !dma_access && !standby |=> conv_done_interrupt || $rose(s_axi_bvalid);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt fell alone");
  c_irq: cover property ($rose(conv_done_interrupt));
  c_dma: cover property (dma_access && conv_done_interrupt);
  c_standby: cover property (standby ##1 !standby);
endmodule

bind adc_control_status_result adc_csr_checker i_adc_csr_checker (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_rdata, .s_axi_rvalid, .standby,
  .dma_access, .sample_start, .sample_channel, .conv_done_interrupt);

/* verification/analog_source_model.sv */
// channel code in the top bits makes every stored result traceable to its input
module analog_source_model (
  input wire logic [2:0] sample_channel,
  output logic [9:0] sample_data
);
  assign sample_data = {sample_channel, 7'h2D};
endmodule

/* verification/tb_adc_control_status_result.sv */
`include "adc_ctrl_defs.svh"

module tb_adc_control_status_result;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic standby, dma_access, sample_start, conv_done_interrupt;
  logic [9:0] sample_data;
  logic [2:0] sample_channel;
  int n_errors = 0;
  int cmp_count = 0;

  always #10 aclk = ~aclk;

  adc_control_status_result i_adc_control_status_result (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .standby, .dma_access, .sample_data, .sample_start, .sample_channel,
    .conv_done_interrupt);
  analog_source_model i_analog_source_model (.sample_channel, .sample_data);

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask

  // bready and rready stay high, so the answer is taken at the edge it is seen
  task automatic wr(input logic [29:0] idx, input logic [7:0] d, input logic [3:0] s);
    int t;
    t = 0;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && t < 99);
    if (!s_axi_bvalid) begin
      n_errors++;
      $display("MISMATCH %0t write response never came", $time);
    end
    chk({30'h0, s_axi_bresp}, {30'h0, `RESP_OKAY});
  endtask

  task automatic rd(input logic [29:0] idx, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && t < 99);
    if (!s_axi_rvalid) begin
      n_errors++;
      $display("MISMATCH %0t read response never came", $time);
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rchk(input logic [29:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
  endtask

  // counts conversion starts until the interrupt shows up
  task automatic wait_irq(output int n);
    n = 0;
    for (int t = 0; t < 900; t++) begin
      @(posedge aclk);
      if (conv_done_interrupt) break;
      if (sample_start) n++;
    end
    chk({31'h0, conv_done_interrupt}, 32'h1);
  endtask

  function automatic logic [31:0] res(input logic [2:0] ch);
    return {16'h0000, ch, 7'h2D, 6'h00};
  endfunction

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    complete_run();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, standby, dma_access} = 5'h00;
    {s_axi_bready, s_axi_rready} = 2'h3;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rchk(`IDX_CONTROL, 32'h00000004);
    for (int i = 0; i < 4; i++) rchk(`IDX_RESULT_A + 30'(2 * i), 32'h0);
    wr(`IDX_RESULT_A, 8'hFF, 4'hF);
    rchk(`IDX_RESULT_A, 32'h0);
    rd(30'h0000010, d, r);
    chk({d[31:2], r}, {30'h0, `RESP_SLVERR});
    $display("test reset_map done");
    wr(`IDX_CONTROL, 8'h9B, 4'hF);
    rchk(`IDX_CONTROL, 32'h0000001B);
    wr(`IDX_CONTROL, 8'h00, 4'hE);
    rchk(`IDX_CONTROL, 32'h0000001B);
    $display("test control_bits done");
    wr(`IDX_CONTROL, 8'h65, 4'hF);
    wait_irq(n);
    chk(n, 32'h1);
    wr(`IDX_CONTROL, 8'h45, 4'hF);
    rchk(`IDX_CONTROL, 32'h000000C5);
    rchk(`IDX_RESULT_B, res(3'h5));
    wr(`IDX_CONTROL, 8'hC5, 4'hF);
    rchk(`IDX_CONTROL, 32'h000000C5);
    wr(`IDX_CONTROL, 8'h45, 4'hF);
    rchk(`IDX_CONTROL, 32'h00000045);
    chk({31'h0, conv_done_interrupt}, 32'h0);
    $display("test single done");
    wr(`IDX_CONTROL, 8'h28, 4'hF);
    // fast conversion must be over well before the slow length
    repeat (160) @(posedge aclk);
    chk({31'h0, conv_done_interrupt}, 32'h0);
    rchk(`IDX_CONTROL, 32'h00000088);
    rchk(`IDX_RESULT_A, res(3'h0));
    wr(`IDX_CONTROL, 8'hE8, 4'hF);
    repeat (2) @(posedge aclk);
    dma_access <= 1'h1;
    @(posedge aclk);
    dma_access <= 1'h0;
    @(posedge aclk);
    chk({31'h0, conv_done_interrupt}, 32'h0);
    wait_irq(n);
    rchk(`IDX_CONTROL, 32'h000000C8);
    $display("test fast_dma done");
    wr(`IDX_CONTROL, 8'h76, 4'hF);
    wait_irq(n);
    chk(n, 32'h3);
    rchk(`IDX_CONTROL, 32'h000000F6);
    rchk(`IDX_RESULT_C, res(3'h6));
    wr(`IDX_CONTROL, 8'h56, 4'hF);
    rchk(`IDX_CONTROL, 32'h00000056);
    n = 0;
    repeat (300) begin
      @(posedge aclk);
      if (sample_start) n++;
    end
    chk(n, 32'h0);
    wr(`IDX_CONTROL, 8'h79, 4'hF);
    wait_irq(n);
    chk(n, 32'h2);
    rchk(`IDX_CONTROL, 32'h000000F9);
    rchk(`IDX_RESULT_B, res(3'h1));
    wr(`IDX_CONTROL, 8'h59, 4'hF);
    rchk(`IDX_CONTROL, 32'h00000059);
    $display("test scan done");
    wr(`IDX_CONTROL, 8'h76, 4'hF);
    repeat (3) @(posedge aclk);
    standby <= 1'h1;
    @(posedge aclk);
    standby <= 1'h0;
    @(posedge aclk);
    rchk(`IDX_CONTROL, 32'h00000004);
    rchk(`IDX_RESULT_C, 32'h0);
    $display("test standby done");
    complete_run();
  end
endmodule
